// File: design/ucsc_pkg.sv
// Constants, codes and carriers of the ULPI command and status codec.
// Assumes a link clock domain for the bus and a system domain for status sources.
package ucsc_pkg;

    localparam int unsigned UCSC_DATA_W = 8;
    localparam logic [7:0] UCSC_BUS_IDLE = 8'h00;

    // Command code in bits 7:6, payload in bits 5:0
    localparam logic [1:0] UCSC_CODE_IDLE = 2'h0;
    localparam logic [1:0] UCSC_CODE_TX   = 2'h1;
    localparam logic [1:0] UCSC_CODE_WR   = 2'h2;
    localparam logic [1:0] UCSC_CODE_RD   = 2'h3;
    localparam logic [5:0] UCSC_PAY_ZERO  = 6'h00;
    localparam logic [5:0] UCSC_PAY_EXT   = 6'h2f;
    localparam logic [1:0] UCSC_PID_HI    = 2'h0;

    // Line state context
    localparam logic [1:0] UCSC_XS_HS      = 2'h0;
    localparam logic [1:0] UCSC_OPM_CHIRP  = 2'h2;
    localparam logic [1:0] UCSC_LS_SQ      = 2'h0;
    localparam logic [1:0] UCSC_LS_NSQ     = 2'h1;
    localparam logic [1:0] UCSC_LS_HSD_HI  = 2'h1;
    localparam logic [1:0] UCSC_LS_HSD_LO  = 2'h2;

    // Vbus state and receive event codes
    localparam logic [1:0] UCSC_VB_LOW  = 2'h0;
    localparam logic [1:0] UCSC_VB_END  = 2'h1;
    localparam logic [1:0] UCSC_VB_SVLD = 2'h2;
    localparam logic [1:0] UCSC_VB_AVLD = 2'h3;
    localparam logic [1:0] UCSC_RX_NONE = 2'h0;
    localparam logic [1:0] UCSC_RX_ACT  = 2'h1;
    localparam logic [1:0] UCSC_RX_ERR  = 2'h3;
    localparam logic [1:0] UCSC_RX_DISC = 2'h2;

    // Byte index within a command
    localparam logic [1:0] UCSC_BYTE_CMD  = 2'h0;
    localparam logic [1:0] UCSC_BYTE_1ST  = 2'h1;
    localparam logic [1:0] UCSC_BYTE_2ND  = 2'h2;
    localparam logic [1:0] UCSC_BYTE_LAST = 2'h3;

    typedef enum logic [2:0] {UCSC_NOOP, UCSC_NOPID, UCSC_PID, UCSC_REGW,
                              UCSC_EXTW, UCSC_REGR, UCSC_EXTR} ucsc_cmd_type;

    typedef enum {UCSC_L_IDLE, UCSC_L_CMD, UCSC_L_TURN, UCSC_L_DRIVE} ucsc_link_state_type;

    typedef struct packed {
        logic       alt_int;
        logic       id;
        logic [1:0] rx_event;
        logic [1:0] vbus;
        logic [1:0] line;
    } ucsc_status_type;

    typedef struct packed {
        logic dp;
        logic dm;
        logic squelch;
        logic hs_diff;
        logic sess_end;
        logic sess_vld;
        logic a_vbus_vld;
        logic id;
        logic rx_active;
        logic rx_error;
        logic host_disc;
        logic b_vld;
    } ucsc_pins_type;

    typedef struct packed {
        logic [1:0] xcvr_select;
        logic       term_select;
        logic [1:0] op_mode;
        logic       dp_pulldown;
        logic       dm_pulldown;
        logic       bvld_rise_en;
        logic       bvld_fall_en;
    } ucsc_cfg_type;

    typedef struct packed {
        ucsc_cmd_type kind;
        logic [3:0]   pid;
        logic [7:0]   addr;
        logic [7:0]   wdata;
    } ucsc_cmd_info_type;

endpackage

// File: design/ucsc_sync.sv
// Two-flop level synchroniser of parameter width.
// Assumes each bit is an independent level; no word coherence.
`timescale 1ns/100ps
module ucsc_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            meta_q <= '0;
            q_out  <= '0;
        end
        else
        begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end
endmodule // ucsc_sync

// File: design/ucsc_top.sv
// ULPI command decoder and status byte sender, device end of the bus.
// Status sources are pins sampled in the system domain; the bus runs on the link clock.
`timescale 1ns/100ps
module ucsc_top
    import ucsc_pkg::*;
(
    input  wire logic                        sys_clk_in,
    input  wire logic                        rst_in,
    input  wire ucsc_pkg::ucsc_pins_type     pins_in,
    input  wire ucsc_pkg::ucsc_cfg_type      cfg_in,
    input  wire logic                        low_power_in,
    output ucsc_pkg::ucsc_status_type        status_out,
    input  wire logic                        ulpi_clk_in,
    input  wire logic [7:0]                  ulpi_data_in,
    output logic      [7:0]                  ulpi_data_out,
    output logic                             ulpi_data_oe_n_out,
    output logic                             ulpi_dir_out,
    output logic                             ulpi_nxt_out,
    input  wire logic                        ulpi_stp_in,
    output logic                             cmd_valid_out,
    output ucsc_pkg::ucsc_cmd_info_type      cmd_out,
    output logic                             tx_active_out,
    output logic                             tx_byte_valid_out,
    output logic      [7:0]                  tx_byte_out,
    output logic                             reg_wr_out,
    output logic                             reg_rd_out,
    input  wire logic [7:0]                  reg_rdata_in
);
    import ucsc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    function automatic ucsc_cmd_type cmd_decode(input logic [7:0] b);
        cmd_decode = UCSC_NOOP;
        case (b[7:6])
            UCSC_CODE_TX:
            begin
                if (b[5:0] == UCSC_PAY_ZERO)
                    cmd_decode = UCSC_NOPID;
                else if (b[5:4] == UCSC_PID_HI)
                    cmd_decode = UCSC_PID;
            end
            UCSC_CODE_WR:
                cmd_decode = (b[5:0] == UCSC_PAY_EXT) ? UCSC_EXTW : UCSC_REGW;
            UCSC_CODE_RD:
                cmd_decode = (b[5:0] == UCSC_PAY_EXT) ? UCSC_EXTR : UCSC_REGR;
            default:
                cmd_decode = UCSC_NOOP;
        endcase
    endfunction

    function automatic logic [1:0] line_enc(input ucsc_pins_type p, input ucsc_cfg_type c);
        logic chirp;
        chirp = (c.dp_pulldown & c.dm_pulldown) ? (c.op_mode == UCSC_OPM_CHIRP) : c.term_select;
        // Raw levels give J and K for either speed in either role
        line_enc = {p.dm, p.dp};
        if (c.xcvr_select == UCSC_XS_HS)
        begin
            if (chirp)
                line_enc = p.squelch ? UCSC_LS_SQ : (p.hs_diff ? UCSC_LS_HSD_HI : UCSC_LS_HSD_LO);
            else
                line_enc = p.squelch ? UCSC_LS_SQ : UCSC_LS_NSQ;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // System domain: status assembly and change detection

    ucsc_pins_type   pins_s;
    ucsc_status_type status_now;
    ucsc_status_type hold_q;
    logic            ack_s;
    logic            req_q;
    logic            alt_q;
    logic            bvld_prev_q;
    logic            alt_ev;
    logic            busy;
    logic            send_now;

    ucsc_sync #(.WIDTH($bits(ucsc_pins_type))) u_pin_sync (
        .clk_in (sys_clk_in),
        .rst_in (rst_in),
        .d_in   (pins_in),
        .q_out  (pins_s)
    );

    always_comb
    begin
        status_now.line     = line_enc(pins_s, cfg_in);
        status_now.vbus     = pins_s.a_vbus_vld ? UCSC_VB_AVLD :
                              pins_s.sess_vld   ? UCSC_VB_SVLD :
                              pins_s.sess_end   ? UCSC_VB_LOW  : UCSC_VB_END;
        status_now.rx_event = pins_s.host_disc  ? UCSC_RX_DISC :
                              !pins_s.rx_active ? UCSC_RX_NONE :
                              pins_s.rx_error   ? UCSC_RX_ERR  : UCSC_RX_ACT;
        status_now.id       = pins_s.id;
        status_now.alt_int  = alt_q;
    end

    assign alt_ev   = (pins_s.b_vld & ~bvld_prev_q & cfg_in.bvld_rise_en) |
                      (~pins_s.b_vld & bvld_prev_q & cfg_in.bvld_fall_en);
    assign busy     = req_q != ack_s;
    // Compared with the last byte sent, so a change of bits 6:0 gone by low-power exit sends nothing
    assign send_now = !busy && !low_power_in &&
                      ((status_now[6:0] != status_out[6:0]) || alt_q);

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            bvld_prev_q <= 1'b0;
            alt_q       <= 1'b0;
        end
        else
        begin
            bvld_prev_q <= pins_s.b_vld;
            // New edge wins over the clear of the byte just sent
            alt_q       <= alt_ev | (alt_q & ~send_now);
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            req_q      <= 1'b0;
            hold_q     <= '0;
            status_out <= '0;
        end
        else if (send_now)
        begin
            req_q      <= ~req_q;
            hold_q     <= status_now;
            status_out <= status_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link domain: handshake receive side

    logic            lrst;
    logic            req_s;
    logic            req_prev_q;
    logic            ack_q;
    logic            pend_q;
    ucsc_status_type rx_byte_q;
    logic            req_edge;
    logic            st_sent;

    ucsc_sync #(.WIDTH(1)) u_rst_sync (
        .clk_in (ulpi_clk_in),
        .rst_in (1'b0),
        .d_in   (rst_in),
        .q_out  (lrst)
    );

    ucsc_sync #(.WIDTH(1)) u_req_sync (
        .clk_in (ulpi_clk_in),
        .rst_in (lrst),
        .d_in   (req_q),
        .q_out  (req_s)
    );

    ucsc_sync #(.WIDTH(1)) u_ack_sync (
        .clk_in (sys_clk_in),
        .rst_in (rst_in),
        .d_in   (ack_q),
        .q_out  (ack_s)
    );

    ucsc_link_state_type state_q;
    logic                rd_sel_q;
    logic [1:0]          cnt_q;
    ucsc_cmd_type        new_kind;
    logic                take_cmd;
    logic                take_st;

    assign req_edge = req_s ^ req_prev_q;
    assign st_sent  = (state_q == UCSC_L_TURN) && !rd_sel_q;

    // Hold word is stable while the toggle is unanswered, so copying it is safe
    always_ff @(posedge ulpi_clk_in)
    begin
        if (lrst)
        begin
            req_prev_q <= 1'b0;
            ack_q      <= 1'b0;
            pend_q     <= 1'b0;
            rx_byte_q  <= '0;
        end
        else
        begin
            req_prev_q <= req_s;
            ack_q      <= req_s;
            pend_q     <= req_edge | (pend_q & ~st_sent);
            if (req_edge)
                rx_byte_q <= hold_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link domain: bus protocol

    assign new_kind = cmd_decode(ulpi_data_in);
    assign take_st  = (state_q == UCSC_L_IDLE) && pend_q && (ulpi_data_in == UCSC_BUS_IDLE);
    assign take_cmd = (state_q == UCSC_L_IDLE) && (ulpi_data_in != UCSC_BUS_IDLE);

    always_ff @(posedge ulpi_clk_in)
    begin
        if (lrst)
        begin
            state_q            <= UCSC_L_IDLE;
            rd_sel_q           <= 1'b0;
            cnt_q              <= UCSC_BYTE_CMD;
            ulpi_data_out      <= UCSC_BUS_IDLE;
            ulpi_data_oe_n_out <= 1'b1;
            ulpi_dir_out       <= 1'b0;
            ulpi_nxt_out       <= 1'b0;
            cmd_valid_out      <= 1'b0;
            cmd_out            <= '0;
            tx_active_out      <= 1'b0;
            tx_byte_valid_out  <= 1'b0;
            tx_byte_out        <= UCSC_BUS_IDLE;
            reg_wr_out         <= 1'b0;
            reg_rd_out         <= 1'b0;
        end
        else
        begin
            cmd_valid_out     <= 1'b0;
            tx_byte_valid_out <= 1'b0;
            reg_wr_out        <= 1'b0;
            reg_rd_out        <= 1'b0;
            case (state_q)
                UCSC_L_IDLE:
                begin
                    if (take_st)
                    begin
                        ulpi_dir_out <= 1'b1;
                        rd_sel_q     <= 1'b0;
                        state_q      <= UCSC_L_TURN;
                    end
                    else if (take_cmd && new_kind != UCSC_NOOP)
                    begin
                        ulpi_nxt_out  <= 1'b1;
                        cmd_valid_out <= 1'b1;
                        cmd_out.kind  <= new_kind;
                        cmd_out.pid   <= ulpi_data_in[3:0];
                        cmd_out.addr  <= {2'h0, ulpi_data_in[5:0]};
                        tx_active_out <= new_kind == UCSC_PID;
                        cnt_q         <= UCSC_BYTE_CMD;
                        state_q       <= UCSC_L_CMD;
                    end
                end
                UCSC_L_CMD:
                begin
                    if (cnt_q != UCSC_BYTE_LAST)
                        cnt_q <= cnt_q + UCSC_BYTE_1ST;
                    case (cmd_out.kind)
                        UCSC_NOPID, UCSC_PID:
                        begin
                            if (ulpi_stp_in)
                            begin
                                ulpi_nxt_out  <= 1'b0;
                                tx_active_out <= 1'b0;
                                state_q       <= UCSC_L_IDLE;
                            end
                            else if (cnt_q != UCSC_BYTE_CMD)
                            begin
                                // Line activity for signalling begins with this byte for NOPID; PID raised it with the command
                                tx_active_out     <= 1'b1;
                                tx_byte_valid_out <= 1'b1;
                                tx_byte_out       <= ulpi_data_in;
                            end
                        end
                        UCSC_REGW, UCSC_EXTW:
                        begin
                            if (ulpi_stp_in)
                            begin
                                ulpi_nxt_out <= 1'b0;
                                reg_wr_out   <= 1'b1;
                                state_q      <= UCSC_L_IDLE;
                            end
                            else if (cnt_q == UCSC_BYTE_1ST && cmd_out.kind == UCSC_EXTW)
                                cmd_out.addr <= ulpi_data_in;
                            else if (cnt_q == UCSC_BYTE_1ST || cnt_q == UCSC_BYTE_2ND)
                                cmd_out.wdata <= ulpi_data_in;
                        end
                        default:
                        begin
                            // Reads turn the bus once the address is known
                            if (cmd_out.kind == UCSC_REGR || cnt_q == UCSC_BYTE_1ST)
                            begin
                                if (cmd_out.kind == UCSC_EXTR)
                                    cmd_out.addr <= ulpi_data_in;
                                ulpi_nxt_out <= 1'b0;
                                ulpi_dir_out <= 1'b1;
                                reg_rd_out   <= 1'b1;
                                rd_sel_q     <= 1'b1;
                                state_q      <= UCSC_L_TURN;
                            end
                        end
                    endcase
                end
                UCSC_L_TURN:
                begin
                    ulpi_data_out      <= rd_sel_q ? reg_rdata_in : rx_byte_q;
                    ulpi_data_oe_n_out <= 1'b0;
                    state_q            <= UCSC_L_DRIVE;
                end
                UCSC_L_DRIVE:
                begin
                    ulpi_data_oe_n_out <= 1'b1;
                    ulpi_dir_out       <= 1'b0;
                    state_q            <= UCSC_L_IDLE;
                end
                default:
                    state_q <= UCSC_L_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_take(ucsc_cmd_type k);
        take_cmd && new_kind == k;
    endsequence

    a_nxt_accept: assert property (@(posedge ulpi_clk_in) disable iff (lrst)
        take_cmd && new_kind != UCSC_NOOP |=> ulpi_nxt_out && cmd_valid_out)
        else $error("NXT not raised after command");
    a_noop_idle: assert property (@(posedge ulpi_clk_in) disable iff (lrst)
        state_q == UCSC_L_IDLE && ulpi_data_in == UCSC_BUS_IDLE && !pend_q |=> !ulpi_nxt_out && !ulpi_dir_out)
        else $error("Idle bus value not treated as no operation");
    a_pid_field: assert property (@(posedge ulpi_clk_in) disable iff (lrst)
        s_take(UCSC_PID) |=> cmd_out.kind == UCSC_PID && cmd_out.pid == $past(ulpi_data_in[3:0]) && tx_active_out)
        else $error("PID not taken from low bits");
    a_nopid_late: assert property (@(posedge ulpi_clk_in) disable iff (lrst)
        s_take(UCSC_NOPID) |=> !tx_active_out ##1 !tx_active_out)
        else $error("Signalling started before next byte");
    a_regw_addr: assert property (@(posedge ulpi_clk_in) disable iff (lrst)
        s_take(UCSC_REGW) |=> cmd_out.addr == {2'h0, $past(ulpi_data_in[5:0])})
        else $error("Immediate write address wrong");
    a_extw_addr: assert property (@(posedge ulpi_clk_in) disable iff (lrst)
        s_take(UCSC_EXTW) ##1 !ulpi_stp_in ##1 !ulpi_stp_in |=> cmd_out.addr == $past(ulpi_data_in))
        else $error("Extended write address not taken");
    a_regr_turn: assert property (@(posedge ulpi_clk_in) disable iff (lrst)
        s_take(UCSC_REGR) |=> ##1 ulpi_dir_out && reg_rd_out ##1 !ulpi_data_oe_n_out)
        else $error("Register read turnaround wrong");
    a_extr_addr: assert property (@(posedge ulpi_clk_in) disable iff (lrst)
        s_take(UCSC_EXTR) |-> ##3 ulpi_dir_out && cmd_out.addr == $past(ulpi_data_in))
        else $error("Extended read address wrong");
    a_rxcmd_byte: assert property (@(posedge ulpi_clk_in) disable iff (lrst)
        st_sent |=> !ulpi_data_oe_n_out && ulpi_dir_out && ulpi_data_out == $past(rx_byte_q))
        else $error("Status byte not driven under DIR");
    a_status_send: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !busy && !low_power_in && status_now[6:0] != status_out[6:0] |=> req_q != $past(req_q))
        else $error("Status change not sent");
    a_lowpower_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        low_power_in |=> $stable(req_q))
        else $error("Status sent during low power");

    c_regw: cover property (@(posedge ulpi_clk_in) disable iff (lrst) reg_wr_out);
    c_rxcmd: cover property (@(posedge ulpi_clk_in) disable iff (lrst) st_sent);
    c_pid_byte: cover property (@(posedge ulpi_clk_in) disable iff (lrst) tx_byte_valid_out);
    c_extr: cover property (@(posedge ulpi_clk_in) disable iff (lrst) s_take(UCSC_EXTR));
endmodule // ucsc_top

// File: tb/ucsc_link_model.sv
// Link-side model: sends command bytes and records device bytes.
// Assumes the bench resolves the shared bus from the device enable.
`timescale 1ns/100ps
module ucsc_link_model (
    input  wire logic       clk_in,
    input  wire logic       dir_in,
    input  wire logic       nxt_in,
    input  wire logic       oe_n_in,
    input  wire logic [7:0] bus_in,
    output logic      [7:0] data_out,
    output logic            stp_out
);
    logic [7:0] rx_last = 8'h00;
    logic       alt_seen = 1'b0;
    int         lost = 0;
    initial
    begin
        data_out = 8'h00;
        stp_out = 1'b0;
    end
    // Any device byte is taken, back to back too
    always @(posedge clk_in)
        if (dir_in === 1'b1 && oe_n_in === 1'b0)
        begin
            rx_last <= bus_in;
            alt_seen <= alt_seen | bus_in[7];
        end
    // Only legal encodings are ever sent
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] d, input logic wr);
        int n;
        n = 0;
        @(posedge clk_in);
        data_out <= cmd;
        // Held across an unexpected DIR, so an aborted access is simply issued again
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (nxt_in !== 1'b1 && n < 50);
        if (n >= 50)
            lost++;
        // Follow-on byte after NXT was sampled high, or after 50 cycles without it
        data_out <= d;
        @(posedge clk_in);
        data_out <= 8'h00;
        stp_out <= wr;
        @(posedge clk_in);
        stp_out <= 1'b0;
        @(posedge clk_in);
    endtask
endmodule // ucsc_link_model

// File: tb/ucsc_top_tb.sv
// Bench of the codec: status bytes, line codes and command decode.
// Assumes the link model on the bus and plain ports for control.
`timescale 1ns/100ps
module ucsc_top_tb;
    import ucsc_pkg::*;
    logic sys_clk, ulpi_clk, rst, low_power, stp, dir, nxt, oe_n, reg_wr, rd_pulse, cmd_vld, tx_vld, tx_act;
    logic [7:0] link_d, dout, bus, rdata, tx_byte;
    logic [7:0] tx_last = 8'h00;
    ucsc_pins_type pins;
    ucsc_cfg_type cfg;
    ucsc_status_type status;
    ucsc_cmd_info_type cmd;
    int fails = 0, comparisons = 0, n_wr = 0, n_rd = 0, n_cmd = 0, n_act = 0;
    logic [28:0] tab [16] = '{{12'h850, 9'h0c0, 8'h49}, {12'h450, 9'h0c0, 8'h4a}, {12'h458, 9'h0c0, 8'h5a},
        {12'h45c, 9'h0c0, 8'h7a}, {12'h452, 9'h0c0, 8'h6a}, {12'h490, 9'h0c0, 8'h42}, {12'h410, 9'h0c0, 8'h46},
        {12'h430, 9'h0c0, 8'h4e}, {12'h250, 9'h000, 8'h48}, {12'h050, 9'h000, 8'h49}, {12'h050, 9'h040, 8'h4a},
        {12'h150, 9'h040, 8'h49}, {12'h450, 9'h14c, 8'h4a}, {12'h850, 9'h14c, 8'h49}, {12'h050, 9'h02c, 8'h4a},
        {12'h350, 9'h00c, 8'h48}};
    // Undriven bus shows all ones, not the last value
    assign bus = oe_n ? (dir ? 8'hff : link_d) : dout;
    ucsc_top dut (.sys_clk_in(sys_clk), .rst_in(rst), .pins_in(pins), .cfg_in(cfg),
        .low_power_in(low_power), .status_out(status), .ulpi_clk_in(ulpi_clk), .ulpi_data_in(bus),
        .ulpi_data_out(dout), .ulpi_data_oe_n_out(oe_n), .ulpi_dir_out(dir), .ulpi_nxt_out(nxt),
        .ulpi_stp_in(stp), .cmd_valid_out(cmd_vld), .cmd_out(cmd), .tx_active_out(tx_act),
        .tx_byte_valid_out(tx_vld), .tx_byte_out(tx_byte), .reg_wr_out(reg_wr), .reg_rd_out(rd_pulse),
        .reg_rdata_in(rdata));
    ucsc_link_model link (.clk_in(ulpi_clk), .dir_in(dir), .nxt_in(nxt), .oe_n_in(oe_n), .bus_in(bus),
        .data_out(link_d), .stp_out(stp));
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial
    begin
        ulpi_clk = 1'b0;
        #1.3;
        forever #3 ulpi_clk = ~ulpi_clk;
    end
    always @(posedge ulpi_clk)
    begin
        if (reg_wr === 1'b1)
            n_wr++;
        if (rd_pulse === 1'b1)
            n_rd++;
        if (cmd_vld === 1'b1)
            n_cmd++;
        if (tx_act === 1'b1)
            n_act++;
        if (tx_vld === 1'b1)
            tx_last <= tx_byte;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic waitrx(input logic [7:0] exp);
        for (int i = 0; i < 300 && link.rx_last !== exp; i++)
            @(posedge ulpi_clk);
        check("device byte", link.rx_last, exp);
    endtask
    task automatic stat(input logic [11:0] p, input logic [8:0] c, input logic [7:0] exp);
        @(posedge sys_clk);
        pins <= p;
        cfg <= c;
        waitrx(exp);
        check("status", status, exp);
    endtask
    task automatic wrap_up;
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Whole run needs well under a millisecond
    initial
    begin
        #2000000;
        fails++;
        wrap_up();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst = 1'b1;
        low_power = 1'b0;
        pins = '0;
        cfg = 9'h0c0;
        rdata = 8'h5a;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        check("bus enable", {5'h00, dir, oe_n, nxt}, 8'h02);
        repeat (4) @(posedge sys_clk);
        check("first status", link.rx_last, 8'h04);
        $display("test reset done");
        foreach (tab[i])
            stat(tab[i][28:17], tab[i][16:8], tab[i][7:0]);
        check("alt before enable", {7'h00, link.alt_seen}, 8'h00);
        // Line change goes out first, the marked byte follows it
        stat(12'h851, 9'h0c2, 8'hc9);
        check("alt after edge", {7'h00, link.alt_seen}, 8'h01);
        @(posedge sys_clk);
        low_power <= 1'b1;
        pins <= 12'h451;
        repeat (40) @(posedge sys_clk);
        check("held in low power", link.rx_last, 8'hc9);
        low_power <= 1'b0;
        waitrx(8'h4a);
        $display("test status done");
        link.xfer(8'h43, 8'h11, 1'b1);
        check("pid kind", 8'(cmd.kind), 8'(UCSC_PID));
        check("pid value", {4'h0, cmd.pid}, 8'h03);
        check("pid byte", tx_last, 8'h11);
        link.xfer(8'h40, 8'h22, 1'b1);
        check("nopid kind", 8'(cmd.kind), 8'(UCSC_NOPID));
        check("nopid byte", tx_last, 8'h22);
        check("active cycles", 8'(n_act), 8'h04);
        link.xfer(8'h85, 8'ha5, 1'b1);
        repeat (3) @(posedge ulpi_clk);
        check("write kind", 8'(cmd.kind), 8'(UCSC_REGW));
        check("write addr", cmd.addr, 8'h05);
        check("write data", cmd.wdata, 8'ha5);
        check("write strobes", 8'(n_wr), 8'h01);
        link.xfer(8'haf, 8'hc4, 1'b1);
        repeat (3) @(posedge ulpi_clk);
        check("ext write kind", 8'(cmd.kind), 8'(UCSC_EXTW));
        check("ext write addr", cmd.addr, 8'hc4);
        link.xfer(8'hc7, 8'h00, 1'b0);
        waitrx(8'h5a);
        check("read kind", 8'(cmd.kind), 8'(UCSC_REGR));
        check("read addr", cmd.addr, 8'h07);
        rdata <= 8'h3c;
        link.xfer(8'hef, 8'h9b, 1'b0);
        waitrx(8'h3c);
        check("ext read kind", 8'(cmd.kind), 8'(UCSC_EXTR));
        check("ext read addr", cmd.addr, 8'h9b);
        check("read strobes", 8'(n_rd), 8'h02);
        check("write total", 8'(n_wr), 8'h02);
        check("accepted commands", 8'(n_cmd), 8'h06);
        check("link timeouts", 8'(link.lost), 8'h00);
        $display("test commands done");
        wrap_up();
    end
endmodule // ucsc_top_tb
